/* File: testbench/rtc_host_model.sv */
// host side model: apb master that issues the tuning handler's commands
module rtc_host_model (
	// clock
	input wire logic clk,
	// apb master side
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	timeunit 1ns;
	timeprecision 1ns;
	logic hung;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		hung = 1'b0;
	end
	// request held until pready is seen high at an edge
	task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 1000);
		if (n >= 1000)
			hung = 1'b1;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released lines show no stale value
		paddr <= ~a;
		pwdata <= ~wd;
	endtask : xfer
endmodule : rtc_host_model

/* File: testbench/tb_top.sv */
// self-checking bench of the tuning handler
`include "rtc_regs.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk;
	logic srst;
	logic psel, penable, pwrite, pready, pslverr, photo_valid;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [11:0] cal_offset;
	logic [15:0] photo_sample;
	logic mod_ref, fll_error_valid, coil_reverse, analog_cal_en;
	logic [4:0] detect_phase;
	logic [39:0] fll_error;
	logic [12:0] synth_r;
	logic [11:0] synth_n;
	logic [5:0] synth_a;
	rtc_pkg::rtc_code_t field_dac_code;
	int error_cnt = 0;
	int checks_done = 0;
	logic [31:0] seed = 32'h8DFB0F53;
	logic [31:0] pseed = 32'h8DFB0F53;

	rtc_tuning_cmd #(.SLOT_CYC(4), .HALF_SW_CYC(64)) u_rtc_tuning_cmd (.clk(clk), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cal_offset(cal_offset), .photo_sample(photo_sample), .photo_valid(photo_valid),
		.mod_ref(mod_ref), .detect_phase(detect_phase), .fll_error(fll_error), .fll_error_valid(fll_error_valid),
		.synth_r(synth_r), .synth_n(synth_n), .synth_a(synth_a), .field_dac_code(field_dac_code),
		.coil_reverse(coil_reverse), .analog_cal_en(analog_cal_en));
	rtc_host_model u_rtc_host_model (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	function automatic logic [31:0] sp(input int r, input int n, input int a);
		return (r << 18) | (n << 6) | a;
	endfunction : sp
	function automatic logic [31:0] isq(input longint v);
		longint q;
		q = 0;
		while ((q + 1) * (q + 1) <= v)
			q++;
		return (q < 1000) ? 32'd1000 : q[31:0];
	endfunction : isq

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// photo samples keep arriving at random so the detector path runs
	always @(posedge clk) begin
		pseed <= lfsr(pseed);
		photo_sample <= pseed[15:0];
		photo_valid <= pseed[16];
	end

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", nm, exp, got);
			error_cnt++;
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		u_rtc_host_model.xfer(1'b1, a, d, r, e);
		chk("write error", 32'h0, {31'h0, e});
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
		logic [31:0] r;
		logic e;
		u_rtc_host_model.xfer(1'b0, a, 32'h0, r, e);
		chk(nm, exp, r);
	endtask : rd
	function automatic logic [31:0] rnd(input int span);
		seed = lfsr(seed);
		return seed % span;
	endfunction : rnd
	task gap(input logic sel, output int n);
		logic s0;
		int k;
		k = 0;
		s0 = sel ? mod_ref : coil_reverse;
		while ((sel ? mod_ref : coil_reverse) === s0 && k < 300) begin
			@(posedge clk);
			k++;
		end
		s0 = sel ? mod_ref : coil_reverse;
		n = 0;
		while ((sel ? mod_ref : coil_reverse) === s0 && n < 300) begin
			@(posedge clk);
			n++;
		end
	endtask : gap
	task dac_wait(input logic [31:0] exp);
		int k;
		k = 0;
		while (field_dac_code !== exp[11:0] && k < 200) begin
			@(posedge clk);
			k++;
		end
		chk("field dac", exp, {20'h0, field_dac_code});
	endtask : dac_wait
	task complete_run;
		$display("comparisons %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run

	initial begin
		int v, r, n, a, g, c;
		srst = 1'b1;
		cal_offset = 12'h000;
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		rd(`RTC_A_PHASE, 24, "phase rst");
		rd(`RTC_A_SYNTH, sp(2610, 1466, 63), "synth rst");
		rd(`RTC_A_SWITCH, 1, "switch rst");
		rd(`RTC_A_OFFSET, 3000, "offset rst");
		rd(`RTC_A_NV_OFFSET, 3000, "stored offset rst");
		dac_wait(3000);
		for (int i = 0; i < 5; i++) begin
			v = (i == 0) ? 31 : rnd(32);
			wr(`RTC_A_PHASE, v);
			rd(`RTC_A_PHASE, v, "phase");
			chk("detect_phase", v, {27'h0, detect_phase});
			wr(`RTC_A_PHASE, 32 + v);
			rd(`RTC_A_PHASE, v, "phase kept");
			r = (i == 0) ? 8191 : 1500 + rnd(6692);
			n = (i == 0) ? 4095 : 800 + rnd(3296);
			a = (i == 1) ? 0 : rnd(64);
			wr(`RTC_A_SYNTH, sp(r, n, a));
			rd(`RTC_A_SYNTH, sp(r, n, a), "synth");
			chk("synth pins", sp(r, n, a), sp(synth_r, synth_n, synth_a));
			wr(`RTC_A_SYNTH, sp(1499, n, a));
			wr(`RTC_A_SYNTH, sp(r, 799, a));
			rd(`RTC_A_SYNTH, sp(r, n, a), "synth kept");
			v = (i == 0) ? 2300 : (i == 1) ? 3600 : 2300 + rnd(1301);
			wr(`RTC_A_OFFSET, v);
			wr(`RTC_A_OFFSET, (i % 2) ? 2299 : 3601);
			rd(`RTC_A_OFFSET, v, "offset");
		end
		wr(`RTC_A_OFFSET, 3000);
		// analog calibration path, drawn at random within the legal span
		v = rnd(4001) - 2000;
		cal_offset <= v[11:0];
		dac_wait(isq(longint'(v) * 1450 + 3000 * 3000));
		rd(`RTC_A_SFREQ, v, "analog offset");
		wr(`RTC_A_SFREQ, 2000);
		dac_wait(isq(2000 * 1450 + 3000 * 3000));
		chk("analog cal", 0, {31'h0, analog_cal_en});
		wr(`RTC_A_SFREQ, 2001);
		rd(`RTC_A_SFREQ, 2000, "sf kept");
		wr(`RTC_A_OFFSET, 2300);
		wr(`RTC_A_SFREQ, -2000);
		dac_wait(isq(2300 * 2300 - 2000 * 1450));
		rd(`RTC_A_DAC, isq(2300 * 2300 - 2000 * 1450), "dac read");
		gap(1'b0, g);
		chk("coil half period", 64, g);
		gap(1'b1, g);
		chk("mod ref half period", 64, g);
		c = 0;
		repeat (256) begin
			@(posedge clk);
			if (fll_error_valid === 1'b1)
				c++;
		end
		chk("fll pulses", 2, c);
		wr(`RTC_A_SWITCH, 0);
		repeat (130) @(posedge clk);
		chk("coil off", 0, {31'h0, coil_reverse});
		wr(`RTC_A_SWITCH, 2);
		rd(`RTC_A_SWITCH, 0, "switch off");
		wr(`RTC_A_SWITCH, 1);
		rd(`RTC_A_SWITCH, 1, "switch on");
		wr(`RTC_A_PHASE, 5);
		wr(`RTC_A_SYNTH, sp(1600, 900, 5));
		wr(`RTC_A_OFFSET, 2500);
		wr(`RTC_A_CTRL, 7);
		rd(`RTC_A_NV_PHASE, 5, "stored phase");
		rd(`RTC_A_NV_SYNTH, sp(1600, 900, 5), "stored synth");
		rd(`RTC_A_NV_OFFSET, 2500, "stored offset");
		wr(`RTC_A_PHASE, 9);
		wr(`RTC_A_SYNTH, sp(1700, 1000, 1));
		wr(`RTC_A_OFFSET, 2600);
		wr(`RTC_A_SWITCH, 0);
		wr(`RTC_A_CTRL, 8);
		rd(`RTC_A_PHASE, 5, "phase restart");
		rd(`RTC_A_SYNTH, sp(1600, 900, 5), "synth restart");
		rd(`RTC_A_OFFSET, 2500, "offset restart");
		rd(`RTC_A_SWITCH, 1, "switch restart");
		rd(`RTC_A_SFREQ, v, "sf restart");
		chk("analog cal restart", 1, {31'h0, analog_cal_en});
		rd(`RTC_A_CTRL, 0, "ctrl read");
		begin
			logic [31:0] q;
			logic e;
			u_rtc_host_model.xfer(1'b0, 8'h2C, 32'h0, q, e);
			chk("unmapped err", 1, {31'h0, e});
			chk("unmapped data", 0, q);
		end
		if (u_rtc_host_model.hung === 1'b1)
			error_cnt++;
		complete_run();
	end
endmodule : tb_top

/* File: verilog/rtc_isqrt.sv */
// bit-serial integer square root for the field dac code
module rtc_isqrt #(
	parameter int OUT_W = 12
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// request
	input wire logic start,
	input wire logic [2*OUT_W-1:0] radicand,
	// answer
	output logic busy,
	output logic done,
	output logic [OUT_W-1:0] root
);
	localparam int IW = $clog2(OUT_W);
	localparam int SQ_LAT = OUT_W + 1;

	rtc_pkg::rtc_sq_state_t state_ff;
	logic [2*OUT_W-1:0] rad_ff;
	logic [OUT_W-1:0] acc_ff;
	logic [OUT_W-1:0] root_ff;
	logic [IW-1:0] idx_ff;
	logic done_ff;
	logic [OUT_W-1:0] trial;
	logic [2*OUT_W-1:0] trial_sq;

	if (OUT_W < 2) begin : g_bad_w
		$error("rtc_isqrt: OUT_W must be at least 2");
	end

	// one result bit per cycle, msb first
	always_comb begin
		trial = acc_ff | (OUT_W'(1) << idx_ff);
		trial_sq = trial * trial;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_ff <= rtc_pkg::RTC_SQ_IDLE;
			rad_ff <= '0;
			acc_ff <= '0;
			root_ff <= '0;
			idx_ff <= '0;
			done_ff <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			case (state_ff)
				rtc_pkg::RTC_SQ_IDLE: begin
					if (start) begin
						rad_ff <= radicand;
						acc_ff <= '0;
						idx_ff <= IW'(OUT_W - 1);
						state_ff <= rtc_pkg::RTC_SQ_RUN;
					end
				end
				rtc_pkg::RTC_SQ_RUN: begin
					if (trial_sq <= rad_ff) begin
						acc_ff <= trial;
					end
					if (idx_ff == '0) begin
						root_ff <= (trial_sq <= rad_ff) ? trial : acc_ff;
						done_ff <= 1'b1;
						state_ff <= rtc_pkg::RTC_SQ_IDLE;
					end else begin
						idx_ff <= idx_ff - 1'b1;
					end
				end
				default: state_ff <= rtc_pkg::RTC_SQ_IDLE;
			endcase
		end
	end

	assign busy = (state_ff == rtc_pkg::RTC_SQ_RUN);
	assign done = done_ff;
	assign root = root_ff;

	a_sq_latency: assert property (@(posedge clk) disable iff (srst)
		start && !busy |-> ##[1:SQ_LAT] done) else $error("root not ready in time");
endmodule : rtc_isqrt

/* File: verilog/rtc_pkg.sv */
// types shared by the tuning handler modules
package rtc_pkg;
	typedef enum {RTC_SQ_IDLE, RTC_SQ_RUN} rtc_sq_state_t;
	typedef logic [11:0] rtc_code_t;
endpackage : rtc_pkg

/* File: verilog/rtc_regs.svh */
// register map, field layout, reset values and timing counts of the tuning handler
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH

`define RTC_A_PHASE 8'h00
`define RTC_A_SYNTH 8'h04
`define RTC_A_SWITCH 8'h08
`define RTC_A_OFFSET 8'h0C
`define RTC_A_SFREQ 8'h10
`define RTC_A_CTRL 8'h14
`define RTC_A_NV_PHASE 8'h18
`define RTC_A_NV_SYNTH 8'h1C
`define RTC_A_NV_OFFSET 8'h20
`define RTC_A_DAC 8'h24
`define RTC_A_STATUS 8'h28

`define RTC_CTRL_SAVE_PH 0
`define RTC_CTRL_SAVE_SP 1
`define RTC_CTRL_SAVE_MO 2
`define RTC_CTRL_RESTART 3

`define RTC_SP_R_LSB 18
`define RTC_SP_N_LSB 6
`define RTC_SP_A_LSB 0

`define RTC_PH_RST 5'h18
`define RTC_R_RST 13'h0A32
`define RTC_N_RST 12'h5BA
`define RTC_A_RST 6'h3F
`define RTC_MO_RST 12'hBB8
`define RTC_DAC_NOM 12'hBB8

`define RTC_R_MIN 13'h05DC
`define RTC_N_MIN 12'h320
`define RTC_MO_MIN 12'h8FC
`define RTC_MO_MAX 12'hE10
`define RTC_DAC_MIN 12'h3E8
`define RTC_SF_LIM 32'sh0000_07D0
`define RTC_SLOPE 11'h5AA

`define RTC_CLK_HZ 50_000_000
`define RTC_MOD_HZ 70
`define RTC_SW_HZ 5
`define RTC_SLOTS 32
`define RTC_SLOT_CYC (`RTC_CLK_HZ / (`RTC_MOD_HZ * `RTC_SLOTS))
`define RTC_HALF_SW_CYC (`RTC_CLK_HZ / (2 * `RTC_SW_HZ))

`endif

/* File: verilog/rtc_tuning_cmd.sv */
// apb tuning handler: detection phase, synthesizer divider, coil field dac
`include "rtc_regs.svh"
// Notes on behaviour
// - phase setting accepted only 0..31; current value readable
// - modulation cycle split into 32 slots, 11.25 degrees per step
// - lock loop error is in-phase photo signal at 70 Hz modulation
// - phase save writes stored copy; reloaded at restart, power-on sets live and stored copy to 24; stored copy readable
// - synthesizer multiplies 10 MHz by 19*(64*N+A)/R
// - divider accepted only R 1500..8191, N 800..4095, A 0..63; triple readable
// - divider save stores triple in use; stored triple readable
// - coil field driven by 12-bit dac code
// - field dac code kept within 1000..4095, 3000 nominal
// - switching enabled reverses coil current at 5 Hz
// - lock loop error averaged over one full switching period
// - switching enabled at every power-on and restart
// - switching command 1 enables, 0 disables; query reads 1 when enabled
// - field offset accepted only 2300..3600
// - field offset readable, saved to stored copy, reloaded, stored copy readable
// - software offset disables analog inputs, range plus or minus 2000
// - dac code is root of offset times slope plus offset squared
module rtc_tuning_cmd #(
	parameter int SLOT_CYC = `RTC_SLOT_CYC,
	parameter int HALF_SW_CYC = `RTC_HALF_SW_CYC,
	parameter int SAMPLE_W = 16,
	parameter int ACC_W = 40,
	parameter logic [10:0] SLOPE = `RTC_SLOPE
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// analog calibration value and photo detector samples
	input wire logic [11:0] cal_offset,
	input wire logic [SAMPLE_W-1:0] photo_sample,
	input wire logic photo_valid,
	// detection and lock loop
	output logic mod_ref,
	output logic [4:0] detect_phase,
	output logic [ACC_W-1:0] fll_error,
	output logic fll_error_valid,
	// synthesizer divider
	output logic [12:0] synth_r,
	output logic [11:0] synth_n,
	output logic [5:0] synth_a,
	// field coil
	output rtc_pkg::rtc_code_t field_dac_code,
	output logic coil_reverse,
	output logic analog_cal_en
);
	logic [4:0] phase_ff;
	logic [4:0] nv_phase_ff;
	logic [12:0] syn_r_ff;
	logic [11:0] syn_n_ff;
	logic [5:0] syn_a_ff;
	logic [12:0] nv_r_ff;
	logic [11:0] nv_n_ff;
	logic [5:0] nv_a_ff;
	logic [11:0] mo_ff;
	logic [11:0] nv_mo_ff;
	logic [11:0] sf_ff;
	logic sw_mode_ff;
	logic sw_en_ff;
	logic [31:0] prdata_ff;
	logic [31:0] slot_cnt_ff;
	logic [4:0] slot_ff;
	logic [31:0] half_cnt_ff;
	logic per_half_ff;
	logic coil_rev_ff;
	logic [ACC_W-1:0] acc_ff;
	logic [ACC_W-1:0] fll_err_ff;
	logic fll_err_valid_ff;
	rtc_pkg::rtc_code_t dac_ff;

	logic wr;
	logic wr_ph;
	logic wr_sp;
	logic wr_sw;
	logic wr_mo;
	logic wr_sf;
	logic wr_ctrl;
	logic ph_ok;
	logic sp_ok;
	logic mo_ok;
	logic sf_ok;
	logic save_ph;
	logic save_sp;
	logic save_mo;
	logic restart;
	logic [12:0] sp_r;
	logic [11:0] sp_n;
	logic [5:0] sp_a;
	logic slot_tick;
	logic half_tick;
	logic nxt_per_half;
	logic [4:0] rel_slot;
	logic [ACC_W-1:0] samp_ext;
	logic [ACC_W-1:0] nxt_acc;
	logic [11:0] freq_sel;
	logic signed [25:0] slope_prod;
	logic [23:0] mo_sq;
	logic signed [25:0] rad_s;
	logic [23:0] radicand;
	logic sq_busy;
	logic sq_done;
	logic [11:0] sq_root;
	logic [31:0] rd_data;
	logic unmapped;

	if (SLOT_CYC < 1 || HALF_SW_CYC < 1 || SAMPLE_W < 2 || ACC_W <= SAMPLE_W) begin : g_bad_par
		$error("rtc_tuning_cmd: parameter values cannot be served");
	end

	// command decode: a write takes effect in the access phase
	assign wr = psel & penable & pwrite;
	assign wr_ph = wr && (paddr == `RTC_A_PHASE);
	assign wr_sp = wr && (paddr == `RTC_A_SYNTH);
	assign wr_sw = wr && (paddr == `RTC_A_SWITCH);
	assign wr_mo = wr && (paddr == `RTC_A_OFFSET);
	assign wr_sf = wr && (paddr == `RTC_A_SFREQ);
	assign wr_ctrl = wr && (paddr == `RTC_A_CTRL);
	assign save_ph = wr_ctrl & pwdata[`RTC_CTRL_SAVE_PH];
	assign save_sp = wr_ctrl & pwdata[`RTC_CTRL_SAVE_SP];
	assign save_mo = wr_ctrl & pwdata[`RTC_CTRL_SAVE_MO];
	assign restart = wr_ctrl & pwdata[`RTC_CTRL_RESTART];

	assign sp_r = pwdata[`RTC_SP_R_LSB+:13];
	assign sp_n = pwdata[`RTC_SP_N_LSB+:12];
	assign sp_a = pwdata[`RTC_SP_A_LSB+:6];
	// phase and divider upper limits are the field widths themselves
	assign ph_ok = (pwdata[31:5] == 27'h0);
	assign sp_ok = !pwdata[31] && sp_r >= `RTC_R_MIN && sp_n >= `RTC_N_MIN;
	assign mo_ok = (pwdata[31:12] == 20'h0) && pwdata[11:0] >= `RTC_MO_MIN
		&& pwdata[11:0] <= `RTC_MO_MAX;
	assign sf_ok = $signed(pwdata) >= -`RTC_SF_LIM && $signed(pwdata) <= `RTC_SF_LIM;

	// detection phase, live and stored
	always_ff @(posedge clk) begin
		if (srst) begin
			phase_ff <= `RTC_PH_RST;
		end else if (restart) begin
			phase_ff <= nv_phase_ff;
		end else if (wr_ph && ph_ok) begin
			phase_ff <= pwdata[4:0];
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			nv_phase_ff <= `RTC_PH_RST;
		end else if (save_ph) begin
			nv_phase_ff <= phase_ff;
		end
	end

	// synthesizer divider triple, live and stored
	always_ff @(posedge clk) begin
		if (srst) begin
			syn_r_ff <= `RTC_R_RST;
			syn_n_ff <= `RTC_N_RST;
			syn_a_ff <= `RTC_A_RST;
		end else if (restart) begin
			syn_r_ff <= nv_r_ff;
			syn_n_ff <= nv_n_ff;
			syn_a_ff <= nv_a_ff;
		end else if (wr_sp && sp_ok) begin
			syn_r_ff <= sp_r;
			syn_n_ff <= sp_n;
			syn_a_ff <= sp_a;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			nv_r_ff <= `RTC_R_RST;
			nv_n_ff <= `RTC_N_RST;
			nv_a_ff <= `RTC_A_RST;
		end else if (save_sp) begin
			nv_r_ff <= syn_r_ff;
			nv_n_ff <= syn_n_ff;
			nv_a_ff <= syn_a_ff;
		end
	end

	// field offset, live and stored
	always_ff @(posedge clk) begin
		if (srst) begin
			mo_ff <= `RTC_MO_RST;
		end else if (restart) begin
			mo_ff <= nv_mo_ff;
		end else if (wr_mo && mo_ok) begin
			mo_ff <= pwdata[11:0];
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			nv_mo_ff <= `RTC_MO_RST;
		end else if (save_mo) begin
			nv_mo_ff <= mo_ff;
		end
	end

	// software offset holds analog inputs off until restart
	always_ff @(posedge clk) begin
		if (srst || restart) begin
			sf_ff <= 12'h000;
			sw_mode_ff <= 1'b0;
		end else if (wr_sf && sf_ok) begin
			sf_ff <= pwdata[11:0];
			sw_mode_ff <= 1'b1;
		end
	end

	// field switching always comes back on at restart
	always_ff @(posedge clk) begin
		if (srst || restart) begin
			sw_en_ff <= 1'b1;
		end else if (wr_sw && pwdata[31:1] == 31'h0) begin
			sw_en_ff <= pwdata[0];
		end
	end

	// modulation slot timer
	assign slot_tick = (slot_cnt_ff == 32'(SLOT_CYC - 1));

	always_ff @(posedge clk) begin
		if (srst) begin
			slot_cnt_ff <= 32'h0;
			slot_ff <= 5'h00;
		end else if (slot_tick) begin
			slot_cnt_ff <= 32'h0;
			slot_ff <= slot_ff + 5'h01;
		end else begin
			slot_cnt_ff <= slot_cnt_ff + 32'h1;
		end
	end

	// switching period runs even when the coil is held, so averaging length never changes
	assign half_tick = (half_cnt_ff == 32'(HALF_SW_CYC - 1));
	assign nxt_per_half = half_tick ? ~per_half_ff : per_half_ff;

	always_ff @(posedge clk) begin
		if (srst) begin
			half_cnt_ff <= 32'h0;
			per_half_ff <= 1'b0;
			coil_rev_ff <= 1'b0;
		end else begin
			half_cnt_ff <= half_tick ? 32'h0 : half_cnt_ff + 32'h1;
			per_half_ff <= nxt_per_half;
			coil_rev_ff <= sw_en_ff & nxt_per_half;
		end
	end

	// in-phase demodulation, reference shifted by the phase slot
	assign rel_slot = slot_ff - phase_ff;
	assign samp_ext = {{(ACC_W - SAMPLE_W){photo_sample[SAMPLE_W-1]}}, photo_sample};

	always_comb begin
		nxt_acc = acc_ff;
		if (photo_valid) begin
			nxt_acc = rel_slot[4] ? acc_ff - samp_ext : acc_ff + samp_ext;
		end
	end

	// error handed on once per full switching period, so no 5 Hz spur
	always_ff @(posedge clk) begin
		if (srst) begin
			acc_ff <= '0;
			fll_err_ff <= '0;
			fll_err_valid_ff <= 1'b0;
		end else if (half_tick && per_half_ff) begin
			acc_ff <= '0;
			fll_err_ff <= nxt_acc;
			fll_err_valid_ff <= 1'b1;
		end else begin
			acc_ff <= nxt_acc;
			fll_err_valid_ff <= 1'b0;
		end
	end

	// field dac code from offset, slope and field offset
	assign freq_sel = sw_mode_ff ? sf_ff : cal_offset;
	assign slope_prod = 26'($signed(freq_sel) * $signed({1'b0, SLOPE}));
	assign mo_sq = mo_ff * mo_ff;
	assign rad_s = slope_prod + $signed({2'b00, mo_sq});
	// legal ranges keep the sum below 2**24; a negative sum floors at zero
	assign radicand = rad_s[25] ? 24'h000000 : rad_s[23:0];

	rtc_isqrt #(
		.OUT_W(12)
	) u_isqrt (
		.clk(clk),
		.srst(srst),
		.start(!sq_busy),
		.radicand(radicand),
		.busy(sq_busy),
		.done(sq_done),
		.root(sq_root)
	);

	always_ff @(posedge clk) begin
		if (srst) begin
			dac_ff <= `RTC_DAC_NOM;
		end else if (sq_done) begin
			dac_ff <= (sq_root < `RTC_DAC_MIN) ? `RTC_DAC_MIN : sq_root;
		end
	end

	// register read mux
	always_comb begin
		rd_data = 32'h0;
		unmapped = 1'b0;
		case (paddr)
			`RTC_A_PHASE: rd_data = {27'h0, phase_ff};
			`RTC_A_SYNTH: rd_data = {1'b0, syn_r_ff, syn_n_ff, syn_a_ff};
			`RTC_A_SWITCH: rd_data = {31'h0, sw_en_ff};
			`RTC_A_OFFSET: rd_data = {20'h0, mo_ff};
			`RTC_A_SFREQ: rd_data = {{20{freq_sel[11]}}, freq_sel};
			`RTC_A_CTRL: rd_data = 32'h0;
			`RTC_A_NV_PHASE: rd_data = {27'h0, nv_phase_ff};
			`RTC_A_NV_SYNTH: rd_data = {1'b0, nv_r_ff, nv_n_ff, nv_a_ff};
			`RTC_A_NV_OFFSET: rd_data = {20'h0, nv_mo_ff};
			`RTC_A_DAC: rd_data = {20'h0, dac_ff};
			`RTC_A_STATUS: rd_data = {29'h0, sq_busy, coil_rev_ff, sw_mode_ff};
			default: unmapped = 1'b1;
		endcase
	end

	// read data captured in the setup cycle, stable through the access phase
	always_ff @(posedge clk) begin
		if (srst) begin
			prdata_ff <= 32'h0;
		end else if (psel && !penable) begin
			prdata_ff <= pwrite ? 32'h0 : rd_data;
		end
	end

	assign prdata = prdata_ff;
	assign pready = 1'b1;
	assign pslverr = psel & penable & unmapped;

	assign mod_ref = slot_ff[4];
	assign detect_phase = phase_ff;
	assign fll_error = fll_err_ff;
	assign fll_error_valid = fll_err_valid_ff;
	// divider outputs feed the 19*(64*N+A)/R synthesizer
	assign synth_r = syn_r_ff;
	assign synth_n = syn_n_ff;
	assign synth_a = syn_a_ff;
	assign field_dac_code = dac_ff;
	assign coil_reverse = coil_rev_ff;
	assign analog_cal_en = !sw_mode_ff;

	a_phase_set: assert property (@(posedge clk) disable iff (srst)
		wr_ph && ph_ok |=> phase_ff == $past(pwdata[4:0])) else $error("phase write lost");
	a_phase_keep: assert property (@(posedge clk) disable iff (srst)
		wr_ph && !ph_ok |=> $stable(phase_ff)) else $error("bad phase taken");
	a_slot_wrap: assert property (@(posedge clk) disable iff (srst)
		slot_tick && slot_ff == 5'h1F |=> slot_ff == 5'h00) else $error("slot count not 32");
	a_synth_limits: assert property (@(posedge clk) disable iff (srst)
		syn_r_ff >= `RTC_R_MIN && syn_n_ff >= `RTC_N_MIN) else $error("divider out of range");
	a_synth_save: assert property (@(posedge clk) disable iff (srst)
		save_sp |=> nv_r_ff == $past(syn_r_ff) && nv_a_ff == $past(syn_a_ff)) else $error("divider not saved");
	a_dac_floor: assert property (@(posedge clk) disable iff (srst)
		field_dac_code >= `RTC_DAC_MIN) else $error("dac below floor");
	a_coil_flip: assert property (@(posedge clk) disable iff (srst)
		half_tick && sw_en_ff && !wr_sw ##1 sw_en_ff |-> coil_rev_ff != $past(coil_rev_ff))
		else $error("coil not reversed");
	a_err_period: assert property (@(posedge clk) disable iff (srst)
		fll_error_valid |-> $past(per_half_ff) && !per_half_ff && $past(half_tick)) else $error("error mid period");
	a_sw_restart: assert property (@(posedge clk) disable iff (srst)
		restart |=> sw_en_ff && analog_cal_en) else $error("restart state wrong");
	a_offset_save: assert property (@(posedge clk) disable iff (srst)
		save_mo |=> nv_mo_ff == $past(mo_ff)) else $error("offset not saved");
	a_sf_mode: assert property (@(posedge clk) disable iff (srst)
		wr_sf && sf_ok |=> !analog_cal_en [*2]) else $error("analog inputs still on");
endmodule : rtc_tuning_cmd
